// file: common/adc_pkg.sv
// shared constants and types for the converter sequence control
package adc_pkg;
    // ------------------------------------------------------------
    // register indices (byte address = index * 4)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_CTL0   = 8'h60;
    localparam logic [7:0] IDX_CTL1   = 8'h61;
    localparam logic [7:0] IDX_CTL2   = 8'h62;
    localparam logic [7:0] IDX_CTL3   = 8'h63;
    localparam logic [7:0] IDX_CTL4   = 8'h64;
    localparam logic [7:0] IDX_CTL5   = 8'h65;
    localparam logic [7:0] IDX_STAT0  = 8'h66;
    localparam logic [7:0] IDX_STAT1  = 8'h67;
    localparam logic [7:0] IDX_BLK_LO = 8'h60;
    localparam logic [7:0] IDX_BLK_HI = 8'h6F;
    localparam logic [7:0] IDX_RES0   = 8'h70;
    localparam logic [4:0] IDX_RES_HI = 5'h0E; // index[7:3] of results
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int P2_POWER  = 7;
    localparam int P2_FAST   = 6;
    localparam int P2_WAIT   = 5;
    localparam int P2_IRQEN  = 1;
    localparam int P2_IRQF   = 0;
    localparam int P4_TEN    = 7;
    localparam int P5_EIGHT  = 6;
    localparam int P5_SCAN   = 5;
    localparam int P5_MULT   = 4;
    localparam int P0_SCF    = 7;
    // ------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------
    localparam logic [7:0] CTL2_RST = 8'h00;
    localparam logic [1:0] CTL3_RST = 2'h0;
    localparam logic [7:0] CTL4_RST = 8'h01;
    localparam logic [5:0] CONV_BASE_CLKS = 6'h10;
    localparam logic [5:0] TEN_BIT_CLKS   = 6'h02;
    localparam logic [2:0] LAST_OF_FOUR   = 3'h3;
    localparam logic [2:0] LAST_OF_EIGHT  = 3'h7;
    localparam logic [1:0] FRZ_FINISH     = 2'h2;
    localparam logic [1:0] FRZ_NOW        = 2'h3;
    localparam int CLK_MHZ = 125;

    // latched sequence request
    typedef struct packed {
        logic       eight;
        logic       scan;
        logic       mult;
        logic [3:0] chan;
    } seq_cfg_type;

    // resolution, sample time, prescale
    typedef struct packed {
        logic       ten_bit;
        logic [1:0] sample;
        logic [4:0] prescale;
    } timing_cfg_type;

    typedef enum logic {SEQ_IDLE, SEQ_RUN} seq_state_type;
endpackage

// file: rtl/clock_prescaler.sv
// modulo prescaler and divide-by-two for the converter clock
`timescale 1ns/1ns
`default_nettype none
module clock_prescaler (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       run,
    input  wire logic [4:0] prescale,
    output logic            conv_clk_q,
    output logic            tick_q
);
    logic [4:0] count_q;

    // count 0..prescale, toggle on wrap; stopped means gated off
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q    <= 5'h00;
            conv_clk_q <= 1'b0;
            tick_q     <= 1'b0;
        end else if (!run) begin
            count_q    <= 5'h00;
            conv_clk_q <= 1'b0;
            tick_q     <= 1'b0;
        end else if (count_q >= prescale) begin
            count_q    <= 5'h00;
            conv_clk_q <= ~conv_clk_q;
            tick_q     <= ~conv_clk_q;  // one per converter period
        end else begin
            count_q    <= count_q + 5'h01;
            tick_q     <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: rtl/conversion_timer.sv
// counts converter clocks across one conversion
`timescale 1ns/1ns
`default_nettype none
module conversion_timer (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       tick,
    input  wire logic       start,
    input  wire logic       abort,
    input  wire logic       hold,
    input  wire logic [5:0] total,
    output logic            busy_q,
    output logic            done_q
);
    logic [5:0] left_q;

    // load on start, count down on ticks unless frozen
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            left_q <= 6'h00;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else if (abort) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else if (start && !busy_q) begin
            left_q <= total;
            busy_q <= 1'b1;
            done_q <= 1'b0;
        end else if (busy_q && tick && !hold) begin
            left_q <= left_q - 6'h01;
            done_q <= (left_q == 6'h01);
            busy_q <= (left_q != 6'h01);
        end else begin
            done_q <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: rtl/adc_sequence_control.sv
// converter control registers, sequencer and completion flags
//
// Notes on behaviour
// - eight multiplexed inputs, results up to ten bits
// - all timing derived from the one system clock
// - control block of sixteen words is decoded
// - four conversions per sequence, eight if select bit set at start
// - single mode: flag sequence complete, then halt
// - scan mode: flag after first sequence, keep restarting
// - per-result completion flag set on load, cleared on read
// - normal clear needs status read first; fast clear on any access
// - writing the second control register aborts the sequence
// - power bit low gates clock, powers down, aborts sequence
// - wait-stop bit halts conversions in wait mode
// - sequence interrupt only while its enable is set
// - sequence interrupt flag is read-only, shows completion
// - writing the third control register aborts the sequence
// - freeze select: continue, reserved, finish then freeze, freeze now
// - writing the fourth register aborts until sequence start
// - resolution bit selects eight or ten bits
// - sample time 2/4/8/16 clocks; total 18..32, plus two at ten bits
// - prescaler divides by field plus one, then by two
// - fourth register resets to prescale one, zeros elsewhere
// - first control register readable in special mode only; here it reads as zero in both modes
// - start write begins sequence, aborts old, clears flags
// - sequence flag clears on start, or first result read if fast
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module adc_sequence_control (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // system state
    input  wire logic        special_mode,
    input  wire logic        wait_mode,
    input  wire logic        background_debug_state,
    // analog core and sequence interrupt
    input  wire logic [9:0]  conv_result,
    output logic             converter_power_up,
    output logic             analog_converter_clk,
    output logic             sample_start_q,
    output logic [3:0]       channel_q,
    output logic             ten_bit_q,
    output logic             sequence_irq_q
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0]             ctl2_q;
    logic [1:0]             freeze_q;
    adc_pkg::timing_cfg_type tcfg_q;
    adc_pkg::seq_cfg_type   scfg_q;
    adc_pkg::seq_state_type state_q;
    logic [2:0]             cc_q;
    logic                   scf_q;
    logic                   first_done_q;
    logic [7:0]             ccf_q;
    logic [7:0]             armed_q;
    logic [9:0]             result_q [8];
    logic                   ready_q;
    logic [31:0]            rdata_q;
    logic                   err_q;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic [7:0] idx;
    logic       acc;
    logic       wr;
    logic       rd;
    logic       in_block;
    logic       in_res;
    logic [2:0] res_sel;

    assign idx      = paddr[9:2];
    assign in_block = (idx >= adc_pkg::IDX_BLK_LO) &&
                      (idx <= adc_pkg::IDX_BLK_HI);
    assign in_res   = (idx[7:3] == adc_pkg::IDX_RES_HI);
    assign res_sel  = idx[2:0];
    assign acc      = psel && penable && ready_q;
    assign wr       = acc && pwrite;
    assign rd       = acc && !pwrite;

    logic w2;
    logic w3;
    logic w4;
    logic w5;
    logic stat_rd;

    assign w2      = wr && (idx == adc_pkg::IDX_CTL2);
    assign w3      = wr && (idx == adc_pkg::IDX_CTL3);
    assign w4      = wr && (idx == adc_pkg::IDX_CTL4);
    assign w5      = wr && (idx == adc_pkg::IDX_CTL5);
    assign stat_rd = rd && ((idx == adc_pkg::IDX_STAT0) ||
                            (idx == adc_pkg::IDX_STAT1));

    // ------------------------------------------------------------
    // control bits
    // ------------------------------------------------------------
    logic powered;
    logic fast_flag_clear;
    logic wait_mode_stop;
    logic sequence_irq_enable;
    logic abort;

    assign powered             = ctl2_q[adc_pkg::P2_POWER];
    assign fast_flag_clear     = ctl2_q[adc_pkg::P2_FAST];
    assign wait_mode_stop      = ctl2_q[adc_pkg::P2_WAIT];
    assign sequence_irq_enable = ctl2_q[adc_pkg::P2_IRQEN];
    // any write to control 2..5 ends the running sequence
    assign abort = w2 || w3 || w4 || w5;

    // control register two; the flag bit is never stored from the bus
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl2_q <= adc_pkg::CTL2_RST;
        end else if (w2) begin
            ctl2_q <= pwdata[7:0];
            ctl2_q[adc_pkg::P2_IRQF] <= 1'b0;
        end
    end

    // freeze select
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            freeze_q <= adc_pkg::CTL3_RST;
        end else if (w3) begin
            freeze_q <= pwdata[1:0];
        end
    end

    // resolution, sample time and prescale
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tcfg_q <= adc_pkg::CTL4_RST;
        end else if (w4) begin
            tcfg_q <= pwdata[7:0];
        end
    end

    // sequence request is latched at the start write
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            scfg_q <= '0;
        end else if (w5) begin
            scfg_q.eight <= pwdata[adc_pkg::P5_EIGHT];
            scfg_q.scan  <= pwdata[adc_pkg::P5_SCAN];
            scfg_q.mult  <= pwdata[adc_pkg::P5_MULT];
            scfg_q.chan  <= pwdata[3:0];
        end
    end

    // ------------------------------------------------------------
    // converter clock and conversion timing
    // ------------------------------------------------------------
    logic       tick;
    logic       busy;
    logic       done;
    logic       hold;
    logic       no_new;
    logic [5:0] sample_clks;
    logic [5:0] total_clks;
    logic       start_conv;

    // gating the prescaler stops the converter clock when powered down
    clock_prescaler u_prescaler (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .run        (powered),
        .prescale   (tcfg_q.prescale),
        .conv_clk_q (analog_converter_clk),
        .tick_q     (tick)
    );

    // sample time 2 << code, then fixed part plus resolution extra
    assign sample_clks = 6'h02 << tcfg_q.sample;
    assign total_clks  = adc_pkg::CONV_BASE_CLKS + sample_clks +
                         (tcfg_q.ten_bit ? adc_pkg::TEN_BIT_CLKS
                                         : 6'h00);

    // wait-mode stop and immediate freeze both hold the timer
    assign hold = (wait_mode_stop && wait_mode) ||
                  (background_debug_state &&
                   freeze_q == adc_pkg::FRZ_NOW);
    // finish-then-freeze only blocks the next conversion
    assign no_new = background_debug_state &&
                    (freeze_q == adc_pkg::FRZ_FINISH);
    assign start_conv = (state_q == adc_pkg::SEQ_RUN) && !busy &&
                        !done && !no_new && !hold && !abort;

    conversion_timer u_timer (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .tick     (tick),
        .start    (start_conv),
        .abort    (abort || !powered),
        .hold     (hold),
        .total    (total_clks),
        .busy_q   (busy),
        .done_q   (done)
    );

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    logic [2:0] last_cc;
    logic       seq_end;

    assign last_cc = scfg_q.eight ? adc_pkg::LAST_OF_EIGHT
                                  : adc_pkg::LAST_OF_FOUR;
    assign seq_end = done && (cc_q == last_cc);

    // run only between a start write and an abort or the end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= adc_pkg::SEQ_IDLE;
        end else begin
            case (state_q)
                adc_pkg::SEQ_IDLE: begin
                    if (w5 && powered) begin
                        state_q <= adc_pkg::SEQ_RUN;
                    end
                end
                adc_pkg::SEQ_RUN: begin
                    if (w5 && powered) begin
                        state_q <= adc_pkg::SEQ_RUN;
                    end else if (abort || !powered) begin
                        state_q <= adc_pkg::SEQ_IDLE;
                    end else if (seq_end && !scfg_q.scan) begin
                        state_q <= adc_pkg::SEQ_IDLE;
                    end
                end
                default: state_q <= adc_pkg::SEQ_IDLE;
            endcase
        end
    end

    // conversion counter wraps, so scan mode restarts by itself
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cc_q <= 3'h0;
        end else if (abort) begin
            cc_q <= 3'h0;
        end else if (done) begin
            cc_q <= seq_end ? 3'h0 : cc_q + 3'h1;
        end
    end

    // channel for each conversion; multichannel steps through a group
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            channel_q      <= 4'h0;
            sample_start_q <= 1'b0;
            ten_bit_q      <= 1'b0;
        end else begin
            sample_start_q <= start_conv;
            ten_bit_q      <= tcfg_q.ten_bit;
            if (start_conv) begin
                if (!scfg_q.mult) begin
                    channel_q <= scfg_q.chan;
                end else if (scfg_q.eight) begin
                    channel_q <= {scfg_q.chan[3], cc_q};
                end else begin
                    channel_q <= {scfg_q.chan[3:2], cc_q[1:0]};
                end
            end
        end
    end

    // ------------------------------------------------------------
    // result storage and completion flags
    // ------------------------------------------------------------
    logic [7:0] res_acc;
    logic [7:0] res_rd;

    // result array; eight-bit mode keeps the top bits right-aligned
    always_ff @(posedge core_clk) begin
        if (done) begin
            result_q[cc_q] <= tcfg_q.ten_bit ? conv_result
                            : {2'b00, conv_result[9:2]};
        end
    end

    // per-flag set and clear; a load in the clear cycle wins
    generate
        for (genvar i = 0; i < 8; i++) begin : g_flag
            assign res_acc[i] = acc && in_res && (res_sel == i);
            assign res_rd[i]  = res_acc[i] && !pwrite;

            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    ccf_q[i]   <= 1'b0;
                    armed_q[i] <= 1'b0;
                end else if (done && cc_q == i) begin
                    ccf_q[i]   <= 1'b1;
                    armed_q[i] <= 1'b0;
                end else if (w5) begin
                    ccf_q[i]   <= 1'b0;
                    armed_q[i] <= 1'b0;
                end else if (fast_flag_clear && res_acc[i]) begin
                    ccf_q[i]   <= 1'b0;
                    armed_q[i] <= 1'b0;
                end else if (!fast_flag_clear && res_rd[i] &&
                             armed_q[i]) begin
                    ccf_q[i]   <= 1'b0;
                    armed_q[i] <= 1'b0;
                end else if (stat_rd && ccf_q[i]) begin
                    armed_q[i] <= 1'b1;
                end
            end
        end
    endgenerate

    // sequence flag: set once per start, fast clear on first result
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            scf_q        <= 1'b0;
            first_done_q <= 1'b0;
        end else if (seq_end && !first_done_q && !abort) begin
            scf_q        <= 1'b1;
            first_done_q <= 1'b1;
        end else if (w5) begin
            scf_q        <= 1'b0;
            first_done_q <= 1'b0;
        end else if (fast_flag_clear && res_rd[0]) begin
            scf_q        <= 1'b0;
        end
    end

    // interrupt line follows flag gated by enable
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sequence_irq_q <= 1'b0;
        end else begin
            sequence_irq_q <= scf_q && sequence_irq_enable;
        end
    end

    assign converter_power_up = ctl2_q[adc_pkg::P2_POWER];

    // ------------------------------------------------------------
    // apb answer: one wait state, so every output is registered
    // ------------------------------------------------------------
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (in_res) begin
            rd_mux[9:0] = result_q[res_sel];
        end else begin
            case (idx)
                adc_pkg::IDX_CTL1: rd_mux[7:0] =
                    special_mode ? 8'h00 : 8'h00;
                adc_pkg::IDX_CTL2: rd_mux[7:0] =
                    {ctl2_q[7:1], scf_q};
                adc_pkg::IDX_CTL3: rd_mux[1:0] = freeze_q;
                adc_pkg::IDX_CTL4: rd_mux[7:0] = tcfg_q;
                adc_pkg::IDX_CTL5: rd_mux[6:0] = scfg_q;
                adc_pkg::IDX_STAT0: begin
                    rd_mux[adc_pkg::P0_SCF] = scf_q;
                    rd_mux[2:0] = cc_q;
                end
                adc_pkg::IDX_STAT1: rd_mux[7:0] = ccf_q;
                default: rd_mux = 32'h0000_0000;
            endcase
        end
    end

    // pready rises in the second access cycle and drops after
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ready_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            err_q   <= 1'b0;
        end else if (psel && penable && !ready_q) begin
            ready_q <= 1'b1;
            rdata_q <= rd_mux;
            err_q   <= !(in_block || in_res);
        end else begin
            ready_q <= 1'b0;
            err_q   <= 1'b0;
        end
    end

    assign pready  = ready_q;
    assign prdata  = rdata_q;
    assign pslverr = err_q;
endmodule
`default_nettype wire

// file: testbench/adc_sva.sv
// port assertions for the converter control block
`timescale 1ns/1ns
`default_nettype none
module adc_sva (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        converter_power_up,
    input wire logic        analog_converter_clk,
    input wire logic        sample_start_q,
    input wire logic [3:0]  channel_q
);
    // ------------------------------------------------------------
    // bus and sequencer relations
    // ------------------------------------------------------------
    default clocking dc @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held past one cycle");
    chk_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("access phase not answered next cycle");
    chk_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error response without ready or with data");
    chk_ready_req: assert property (pready |-> psel && penable)
        else $error("ready without a request");
    // one cycle grace, the clock register follows the power bit
    chk_clk_gated: assert property (
        !converter_power_up && !$past(converter_power_up)
        |-> !analog_converter_clk)
        else $error("converter clock runs while powered down");
    chk_start_power: assert property (sample_start_q |-> converter_power_up)
        else $error("conversion started while powered down");
    chk_start_pulse: assert property (sample_start_q |=> !sample_start_q [*3])
        else $error("conversion starts too close together");
    chk_chan_hold: assert property (
        sample_start_q |=> ##1 $stable(channel_q) [*2])
        else $error("channel moved during conversion");
    cov_start: cover property (sample_start_q);
    cov_err: cover property (pslverr);
    cov_power: cover property (!converter_power_up ##1 converter_power_up);
endmodule
bind adc_sequence_control adc_sva u_adc_sva (.*);
`default_nettype wire

// file: testbench/analog_core_model.sv
// behavioural analog core: returns a channel-coded result
`timescale 1ns/1ns
`default_nettype none
module analog_core_model (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       converter_power_up,
    input  wire logic       sample_start_q,
    input  wire logic [3:0] channel_q,
    output logic [9:0]      conv_result
);
    logic start_d_q;
    // ------------------------------------------------------------
    // sample and hold
    // ------------------------------------------------------------
    // code taken a cycle after the pulse so the channel has settled;
    // unpowered the output toggles, so a stale capture cannot match
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            start_d_q   <= 1'b0;
            conv_result <= 10'h155;
        end else begin
            start_d_q <= sample_start_q;
            if (!converter_power_up)
                conv_result <= ~conv_result;
            else if (start_d_q)
                conv_result <= {channel_q, 6'h2A};
        end
    end
endmodule
`default_nettype wire

// file: testbench/adc_sequence_control_tb.sv
// self-checking bench for the converter control block
`timescale 1ns/1ns
`default_nettype none
module adc_sequence_control_tb;
    localparam logic [7:0] C2 = adc_pkg::IDX_CTL2;
    localparam logic [7:0] C4 = adc_pkg::IDX_CTL4;
    localparam logic [7:0] C5 = adc_pkg::IDX_CTL5;
    localparam logic [7:0] S0 = adc_pkg::IDX_STAT0;
    localparam logic [7:0] S1 = adc_pkg::IDX_STAT1;
    localparam logic [7:0] R0 = adc_pkg::IDX_RES0;
    logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic        special_mode, wait_mode, background_debug_state, err_q;
    logic        converter_power_up, analog_converter_clk, sample_start_q;
    logic        ten_bit_q, sequence_irq_q;
    logic [3:0]  channel_q;
    logic [9:0]  conv_result;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int          err_total, num_checks, pulses, cyc, last_c, gap, d, p;
    // ------------------------------------------------------------
    // clock, instances, monitors
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    adc_sequence_control u_adc_sequence_control (.*);
    analog_core_model    u_analog_core_model (.*);
    // start pulses and their spacing; hang guard far above the run
    always @(posedge core_clk) begin
        cyc++;
        if (sample_start_q === 1'b1) begin
            pulses++;
            gap = cyc - last_c;
            last_c = cyc;
        end
        if (cyc > 30000) begin
            err_total++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        if (err_total == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    // request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [7:0] v);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, a, 2'h0};
        pwdata <= {24'h0, v};
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 8'h00);
        chk(rd, exp);
    endtask
    task automatic span(input int n);
        d = pulses;
        repeat (n) @(posedge core_clk);
        d = pulses - d;
    endtask
    // poll until the sequence flag shows
    task automatic wait_seq();
        repeat (400) begin
            apb(1'b0, S0, 8'h00);
            if (rd[7] === 1'b1) break;
        end
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        special_mode <= 1'b1;
        rdc(C4, 32'h01);
        rdc(C2, 32'h00);
        rdc(S1, 32'h00);
        apb(1'b1, C2 - 8'h1, 8'hFF);
        rdc(C2 - 8'h1, 32'h00);
        apb(1'b0, 8'h90, 8'h00);
        chk({rd[30:0], err_q}, 32'h1);
        special_mode <= 1'b0;
        chk(pulses, 0);
    endtask
    task automatic t_single();
        apb(1'b1, C2, 8'h82);
        span(20);
        p = pulses;
        apb(1'b1, C5, 8'h10);
        wait_seq();
        chk(gap >= 72 && gap <= 78, 1);
        chk(sequence_irq_q, 1);
        rdc(C2, 32'h83);
        rdc(S1, 32'h0F);
        rdc(R0 + 8'h3, 32'h3A);
        rdc(S1, 32'h07);
        span(200);
        chk(pulses - p, 4);
    endtask
    task automatic t_fast();
        apb(1'b1, C2, 8'hC1);
        apb(1'b1, C4, 8'hE1);
        p = pulses;
        apb(1'b1, C5, 8'h50);
        wait_seq();
        chk(gap >= 136 && gap <= 142, 1);
        chk({sequence_irq_q, ten_bit_q}, 2'b01);
        rdc(R0, 32'h02A);
        rdc(S1, 32'hFE);
        apb(1'b0, S0, 8'h00);
        chk(rd[7], 0);
        rdc(C2, 32'hC0);
        chk(pulses - p, 8);
    endtask
    task automatic t_scan();
        apb(1'b1, C4, 8'h01);
        apb(1'b1, C2, 8'h80);
        apb(1'b1, C5, 8'h20);
        wait_seq();
        span(400);
        chk(d > 3, 1);
        apb(1'b1, C5, 8'h20);
        rdc(S1, 32'h00);
        apb(1'b0, S0, 8'h00);
        chk(rd[7], 0);
        // writes to control two, three and four each abort a run
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, C5, 8'h20);
            apb(1'b1, C2 + 8'(i), i == 0 ? 8'h80 : 8'(i >> 1));
            span(300);
            chk(d, 0);
        end
    endtask
    task automatic t_hold();
        apb(1'b1, C2, 8'hA0);
        wait_mode <= 1'b1;
        apb(1'b1, C5, 8'h20);
        span(300);
        chk(d < 2, 1);
        wait_mode <= 1'b0;
        span(300);
        chk(d > 0, 1);
        apb(1'b1, C2 + 8'h1, 8'h03);
        background_debug_state <= 1'b1;
        apb(1'b1, C5, 8'h20);
        span(300);
        chk(d < 2, 1);
        apb(1'b1, C2 + 8'h1, 8'h00);
        apb(1'b1, C5, 8'h20);
        span(300);
        chk(d > 0, 1);
        background_debug_state <= 1'b0;
        apb(1'b1, C2, 8'h00);
        apb(1'b1, C5, 8'h20);
        span(300);
        chk({d == 0, analog_converter_clk, converter_power_up}, 3'h4);
    endtask
    initial begin
        {psel, penable, pwrite, special_mode, wait_mode,
         background_debug_state} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        rst_n = 1'b0;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        t_regs();
        t_single();
        t_fast();
        t_scan();
        t_hold();
        wrap_up();
    end
endmodule
`default_nettype wire
